// ===== sbsp_pkg.sv
// shared constants and types for the sync burst sram port
package sbsp_pkg;

  // organization variants: 1M x 18, 512K x 32, 512K x 36
  localparam int ADDR_W_X18  = 20;
  localparam int DATA_W_X18  = 18;
  localparam int LANES_X18   = 2;
  localparam int ADDR_W_X32  = 19;
  localparam int DATA_W_X32  = 32;
  localparam int LANES_X32   = 4;
  localparam int ADDR_W_X36  = 19;
  localparam int DATA_W_X36  = 36;
  localparam int LANES_X36   = 4;

  // burst counter width and step
  localparam int         LSB_W    = 2;
  localparam logic [1:0] LSB_ZERO = 2'h0;
  localparam logic [1:0] LSB_STEP = 2'h1;

  // mode pin levels
  localparam logic FLOW_THRU_LEVEL   = 1'h0;
  localparam logic ORDER_LIN_LEVEL   = 1'h0;
  // level a floating mode pin settles to: pipeline, interleaved, awake
  localparam logic FLOW_FLOAT_LEVEL  = 1'h1;
  localparam logic ORDER_FLOAT_LEVEL = 1'h1;
  localparam logic SLEEP_IDLE_LEVEL  = 1'h0;

  typedef enum logic [0:0] {
    SBSP_DESELECTED,
    SBSP_SELECTED
  } sbsp_acc_type;

endpackage : sbsp_pkg

// ===== sbsp_burst_counter.sv
// 2-bit burst counter with linear or interleaved order
module sbsp_burst_counter (
  input  wire logic       mclk,       // device clock
  input  wire logic       rstn,       // async reset, active low
  input  wire logic       load,       // preset from address lsbs
  input  wire logic [1:0] load_lsbs,  // address lsbs at load
  input  wire logic       step,       // advance this cycle
  input  wire logic       linear,     // 1 linear, 0 interleaved
  output logic      [1:0] acc_lsbs    // lsbs used this cycle
);

  typedef struct packed {
    logic [1:0] start;
    logic [1:0] count;
  } sbsp_cnt_type;

  sbsp_cnt_type st_reg;
  sbsp_cnt_type st_next;

  function automatic logic [1:0] sbsp_order(
    input logic [1:0] start,
    input logic [1:0] count,
    input logic       lin
  );
    sbsp_order = lin ? 2'(start + count) : (start ^ count);
  endfunction : sbsp_order

  always_comb
  begin
    st_next  = st_reg;
    acc_lsbs = sbsp_order(st_reg.start, st_reg.count, linear);
    if (load)
    begin
      st_next.start = load_lsbs;
      st_next.count = sbsp_pkg::LSB_ZERO;
      acc_lsbs      = load_lsbs;
    end
    else if (step)
    begin
      st_next.count = 2'(st_reg.count + sbsp_pkg::LSB_STEP);
      acc_lsbs      = sbsp_order(st_reg.start, st_next.count, linear);
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

endmodule : sbsp_burst_counter

// ===== sbsp_array.sv
// storage array with per-lane write and asynchronous read
module sbsp_array #(
  parameter int ADDR_W = sbsp_pkg::ADDR_W_X18,  // word address bits
  parameter int DATA_W = sbsp_pkg::DATA_W_X18,  // word width
  parameter int LANES  = sbsp_pkg::LANES_X18    // byte lanes
) (
  input  wire logic              mclk,     // device clock
  input  wire logic [LANES-1:0]  wr_mask,  // lanes written this edge
  input  wire logic [ADDR_W-1:0] addr,     // word accessed
  input  wire logic [DATA_W-1:0] wr_data,  // write data
  output logic      [DATA_W-1:0] rd_data   // word at addr
);

  localparam int LANE_W = DATA_W / LANES;

  // no reset: contents only change by writes, so sleep keeps them
  logic [DATA_W-1:0] mem [2**ADDR_W];

  assign rd_data = mem[addr];

  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < LANES; i++)
    begin
      if (wr_mask[i])
        mem[addr][i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
    end
  end

endmodule : sbsp_array

// ===== sbsp_port.sv
// synchronous burst sram host port, single cycle deselect
module sbsp_port #(
  parameter int ADDR_W = sbsp_pkg::ADDR_W_X18,  // word address bits
  parameter int DATA_W = sbsp_pkg::DATA_W_X18,  // word width
  parameter int LANES  = sbsp_pkg::LANES_X18    // byte lanes
) (
  input  wire logic              mclk,                         // device clock
  input  wire logic              rstn,                         // reset, low
  input  wire logic [ADDR_W-1:0] addr,                         // address
  input  wire logic [DATA_W-1:0] dq_in,                        // data pins in
  input  wire logic              chip_select_n,                // select, low
  input  wire logic              processor_address_strobe_n,   // strobe, low
  input  wire logic              controller_address_strobe_n,  // strobe, low
  input  wire logic              burst_step_n,                 // advance, low
  input  wire logic              byte_write_enable_n,          // lane wr, low
  input  wire logic              global_write_n,               // all wr, low
  input  wire logic [LANES-1:0]  lane_write_select_n,          // lanes, low
  input  wire logic              output_enable_n,              // drive, low
  input  wire logic              sleep_request,                // sleep, high
  input  wire logic              flow_through_select,          // 0 flow
  input  wire logic              linear_order_select,          // 0 linear
  output logic      [DATA_W-1:0] dq_out,                       // data pins out
  output logic                   dq_oe,                        // pins driven
  output logic                   sleep_active                  // sleeping
);

  typedef struct packed {
    logic                     sleep_meta;
    logic                     sleep_sync;
    logic                     flow_meta;
    logic                     flow_sync;
    logic                     order_meta;
    logic                     order_sync;
    sbsp_pkg::sbsp_acc_type   state;
    logic [ADDR_W-1:sbsp_pkg::LSB_W] upper;
    logic [DATA_W-1:0]        flow_data;
    logic                     flow_valid;
    logic [DATA_W-1:0]        out_data;
    logic                     out_drive;
    logic                     sleeping;
  } sbsp_state_type;

  sbsp_state_type st_reg;
  sbsp_state_type st_next;

  logic              oe_reg;
  logic              oe_kill;
  logic              awake;
  logic              strobe_p;
  logic              strobe_c;
  logic              any_strobe;
  logic              load_cmd;
  logic              deselect_cmd;
  logic              cont_cmd;
  logic              access;
  logic              is_write;
  logic              is_read;
  logic              step;
  logic              linear;
  logic              flow_mode;
  logic [1:0]        acc_lsbs;
  logic [ADDR_W-1:0] acc_addr;
  logic [LANES-1:0]  wr_mask;
  logic [DATA_W-1:0] rd_data;

  // sleep blocks every command so the array is left untouched
  assign awake      = !st_reg.sleep_sync;
  assign strobe_p   = !processor_address_strobe_n;
  assign strobe_c   = !controller_address_strobe_n;
  assign any_strobe = strobe_p || strobe_c;
  assign linear     = (st_reg.order_sync == sbsp_pkg::ORDER_LIN_LEVEL);
  assign flow_mode  = (st_reg.flow_sync == sbsp_pkg::FLOW_THRU_LEVEL);

  // a fresh load is legal in any cycle, burst or not
  assign load_cmd = awake && any_strobe && !chip_select_n;

  // strobe with chip select high deselects
  assign deselect_cmd = awake && any_strobe && chip_select_n;

  // burst continues only while selected and no strobe is seen
  assign cont_cmd = awake && !any_strobe &&
                    (st_reg.state == sbsp_pkg::SBSP_SELECTED);

  assign access = load_cmd || cont_cmd;

  // step low advances during a burst
  assign step = cont_cmd && !burst_step_n;

  // no write control means a read
  // a processor strobe cycle is always a read; its write follows
  assign is_write = access && !(load_cmd && strobe_p) &&
                    (!global_write_n || !byte_write_enable_n);
  assign is_read  = access && !is_write;

  always_comb
  begin
    wr_mask = '0;
    if (is_write)
    begin
      if (!global_write_n)
        wr_mask = '1;
      // byte write takes only selected lanes
      else
        wr_mask = ~lane_write_select_n;
    end
  end

  // order chosen by the synchronised mode pin
  sbsp_burst_counter u_counter (
    .mclk      (mclk),
    .rstn      (rstn),
    .load      (load_cmd),
    .load_lsbs (addr[sbsp_pkg::LSB_W-1:0]),
    .step      (step),
    .linear    (linear),
    .acc_lsbs  (acc_lsbs)
  );

  assign acc_addr = load_cmd ? {addr[ADDR_W-1:sbsp_pkg::LSB_W], acc_lsbs}
                             : {st_reg.upper, acc_lsbs};

  // width and depth follow the variant parameters
  sbsp_array #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W),
    .LANES  (LANES)
  ) u_array (
    .mclk    (mclk),
    .wr_mask (wr_mask),
    .addr    (acc_addr),
    .wr_data (dq_in),
    .rd_data (rd_data)
  );

  always_comb
  begin
    st_next = st_reg;

    // sleep is asynchronous, so it is synchronised before the commands use it
    st_next.sleep_meta = sleep_request;
    st_next.sleep_sync = st_reg.sleep_meta;
    // mode pins start from their floating defaults after reset
    st_next.flow_meta  = flow_through_select;
    st_next.flow_sync  = st_reg.flow_meta;
    st_next.order_meta = linear_order_select;
    st_next.order_sync = st_reg.order_meta;
    st_next.sleeping   = st_reg.sleep_sync;

    // all commands are taken on this rising edge only
    if (load_cmd)
    begin
      st_next.state = sbsp_pkg::SBSP_SELECTED;
      st_next.upper = addr[ADDR_W-1:sbsp_pkg::LSB_W];
    end
    else if (deselect_cmd)
    begin
      st_next.state = sbsp_pkg::SBSP_DESELECTED;
    end

    // first stage: array word read at this edge
    st_next.flow_valid = is_read;
    if (is_read)
      st_next.flow_data = rd_data;

    if (flow_mode)
    begin
      // read data bypasses the first stage flow_data register
      st_next.out_drive = is_read;
      st_next.out_data  = is_read ? rd_data : st_reg.out_data;
    end
    else
    begin
      // pipeline presents the stored word one cycle later
      // a deselect or write cuts the late read at once
      st_next.out_drive = st_reg.flow_valid && awake &&
                          !deselect_cmd && !is_write;
      st_next.out_data  = st_reg.flow_data;
    end
  end

  // nothing but reset changes without clock edges, so data is kept
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg            <= '0;
      st_reg.sleep_meta <= sbsp_pkg::SLEEP_IDLE_LEVEL;
      st_reg.sleep_sync <= sbsp_pkg::SLEEP_IDLE_LEVEL;
      st_reg.flow_meta  <= sbsp_pkg::FLOW_FLOAT_LEVEL;
      st_reg.flow_sync  <= sbsp_pkg::FLOW_FLOAT_LEVEL;
      st_reg.order_meta <= sbsp_pkg::ORDER_FLOAT_LEVEL;
      st_reg.order_sync <= sbsp_pkg::ORDER_FLOAT_LEVEL;
      st_reg.state      <= sbsp_pkg::SBSP_DESELECTED;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // output enable and sleep clear the drive without a clock
  // outputs drive only while output enable is low
  // re-enabling waits for the next edge, which keeps the pin glitch free
  assign oe_kill = !rstn || output_enable_n || sleep_request;

  always_ff @(posedge mclk or posedge oe_kill)
  begin
    if (oe_kill)
      oe_reg <= 1'h0;
    else
      oe_reg <= st_next.out_drive;
  end

  assign dq_out       = st_reg.out_data;
  assign dq_oe        = oe_reg;
  assign sleep_active = st_reg.sleeping;

endmodule : sbsp_port

// ===== sbsp_host_model.sv
// host bus driver: one command per clock
module sbsp_host_model (
  input  wire logic        mclk,                         // clock
  output logic      [19:0] addr,                         // address
  output logic      [17:0] dq_in,                        // data
  output logic             chip_select_n,                // select
  output logic             processor_address_strobe_n,   // strobe
  output logic             controller_address_strobe_n,  // strobe
  output logic             burst_step_n,                 // advance
  output logic             byte_write_enable_n,          // lane wr
  output logic             global_write_n,               // all wr
  output logic      [1:0]  lane_write_select_n           // lanes
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] ctl_n;
  assign {chip_select_n, processor_address_strobe_n, controller_address_strobe_n, burst_step_n,
          byte_write_enable_n, global_write_n, lane_write_select_n} = ctl_n;
  initial
  begin
    ctl_n = 8'hff;
    addr  = 20'h0_0000;
    dq_in = 18'h0_0000;
  end
  // data only on writes; a released bus shows the inverse, not the last value
  task automatic drive(input logic [7:0] c, input logic [19:0] a, input logic [17:0] d);
    @(posedge mclk);
    #1;
    ctl_n = ~c;
    addr  = a;
    dq_in = (c[3] || c[2]) ? d : ~dq_in;
  endtask : drive
endmodule : sbsp_host_model

// ===== sbsp_port_checker.sv
// pin-level checks on the sram port
module sbsp_port_checker #(
  parameter int ADDR_W = sbsp_pkg::ADDR_W_X18,  // address bits
  parameter int DATA_W = sbsp_pkg::DATA_W_X18,  // width
  parameter int LANES  = sbsp_pkg::LANES_X18    // lanes
) (
  input wire logic              mclk,                         // clock
  input wire logic              rstn,                         // reset
  input wire logic [ADDR_W-1:0] addr,                         // address
  input wire logic [DATA_W-1:0] dq_in,                        // data in
  input wire logic              chip_select_n,                // select
  input wire logic              processor_address_strobe_n,   // strobe
  input wire logic              controller_address_strobe_n,  // strobe
  input wire logic              byte_write_enable_n,          // lane wr
  input wire logic              global_write_n,               // all wr
  input wire logic              output_enable_n,              // oe
  input wire logic              sleep_request,                // sleep
  input wire logic              flow_through_select,          // mode
  input wire logic [DATA_W-1:0] dq_out,                       // data out
  input wire logic              dq_oe,                        // driven
  input wire logic              sleep_active                  // asleep
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire stb   = !processor_address_strobe_n || !controller_address_strobe_n;
  wire nowr  = global_write_n && byte_write_enable_n;
  wire rd    = stb && !chip_select_n && (!processor_address_strobe_n || nowr);
  wire wr    = stb && !chip_select_n && processor_address_strobe_n && !nowr;
  wire dsl   = stb && chip_select_n;
  // both sleep paths clear, so commands are honoured
  wire awake = !sleep_request && !sleep_active;
  property p_oe_gate; output_enable_n |-> !dq_oe; endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("driving with oe high");
  property p_sleep_gate; sleep_request |-> !dq_oe; endproperty
  a_sleep_gate: assert property (p_sleep_gate) else $error("driving in sleep");
  property p_sleep_enter; sleep_request[*5] |-> sleep_active; endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");
  property p_sleep_leave; !sleep_request[*5] |-> !sleep_active; endproperty
  a_sleep_leave: assert property (p_sleep_leave) else $error("sleep not left");
  property p_desel_off; awake && dsl |=> !dq_oe; endproperty
  a_desel_off: assert property (p_desel_off) else $error("drive after deselect");
  property p_write_quiet; awake && wr |=> !dq_oe; endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("drive after write");
  property p_flow_read;
    (!flow_through_select && awake)[*3] ##0 rd ##1 (!output_enable_n && !sleep_request) |-> dq_oe;
  endproperty
  a_flow_read: assert property (p_flow_read) else $error("flow read late");
  // a burst write in the third cycle legally cuts the late word, so only reads count
  property p_pipe_read;
    (flow_through_select && awake)[*3] ##0 dsl ##1 (rd && awake)
      ##1 (!stb && nowr && !output_enable_n && awake)
      |-> !dq_oe ##1 (dq_oe || output_enable_n || sleep_request);
  endproperty
  a_pipe_read: assert property (p_pipe_read) else $error("pipeline latency");
  property p_wr_readback;
    (!flow_through_select && awake)[*3] ##0 (wr && !global_write_n)
      ##1 (rd && awake && addr == $past(addr)) |=> dq_out == $past(dq_in, 2);
  endproperty
  a_wr_readback: assert property (p_wr_readback) else $error("readback differs");
  c_flow_read: cover property (rd && !flow_through_select);
  c_deselect: cover property (awake && dsl);
  c_sleep: cover property ($rose(sleep_active));
endmodule : sbsp_port_checker
bind sbsp_port sbsp_port_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .LANES(LANES)) u_chk (.*);

// ===== sbsp_port_bench.sv
// self-checking bench for the sram port
module sbsp_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk, rstn, output_enable_n, sleep_request, flow_through_select;
  logic        linear_order_select, chip_select_n, processor_address_strobe_n;
  logic        controller_address_strobe_n, burst_step_n, byte_write_enable_n;
  logic        global_write_n, dq_oe, sleep_active;
  logic [1:0]  lane_write_select_n;
  logic [19:0] addr;
  logic [17:0] dq_in, dq_out;
  logic [17:0] m [8];
  int          num_errors, n_tests;
  sbsp_port u_sbsp_port (.*);
  sbsp_host_model u_sbsp_host_model (.*);
  initial
  begin
    mclk = 0;
    forever #25 mclk = ~mclk;
  end
  // command code: select pstrobe cstrobe step lanewr allwr lane1 lane0, active high
  task automatic cmd(input logic [7:0] c, input int a = 0, input logic [17:0] d = 18'h0_0000);
    u_sbsp_host_model.drive(c, a[19:0], d);
  endtask : cmd
  task automatic chk_d(input string s, input logic [17:0] e, input logic [17:0] g);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask : chk_d
  task automatic chk_f(input string s, input logic e, input logic g);
    chk_d(s, {17'h0_0000, e}, {17'h0_0000, g});
  endtask : chk_f
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  initial
  begin
    #20000;
    num_errors++;
    give_verdict();
  end
  initial
  begin
    {rstn, output_enable_n, sleep_request, flow_through_select, linear_order_select} = 5'h00;
    num_errors = 0;
    n_tests = 0;
    repeat (3) @(posedge mclk);
    #1 rstn = 1;
    chk_f("oe_reset", 1'b0, dq_oe);
    chk_f("sleep_reset", 1'b0, sleep_active);
    for (int i = 4; i < 8; i++)
    begin
      m[i] = {14'h2a5a, i[3:0]};
      cmd(8'ha4, i, m[i]);
    end
    cmd(8'ha9, 5, 18'h3_ffff);
    m[5][8:0] = 9'h1ff;
    cmd(8'hac, 6);
    m[6] = 18'h0_0000;
    cmd(8'ha0, 6);
    cmd(8'ha8, 7, 18'h3_ffff);
    chk_d("global_write", m[6], dq_out);
    cmd(8'h24, 5);
    cmd(8'ha0, 5);
    for (int k = 1; k < 5; k++)
    begin
      cmd(k < 4 ? 8'h90 : 8'h20);
      chk_d("linear", m[4 + k % 4], dq_out);
    end
    cmd(8'h00);
    chk_f("flow_desel", 1'b0, dq_oe);
    $display("test flow burst done");
    cmd(8'ha0, 5);
    cmd(8'hc0, 7);
    chk_d("load_5", m[5], dq_out);
    cmd(8'hc4, 6, 18'h1_2345);
    chk_d("load_7", m[7], dq_out);
    cmd(8'h20);
    chk_d("load_6", m[6], dq_out);
    $display("test reload done");
    flow_through_select = 1;
    linear_order_select = 1;
    repeat (3) cmd(8'h00);
    cmd(8'ha0, 6);
    for (int k = 1; k < 7; k++)
    begin
      cmd(k < 5 ? 8'h90 : (k == 5 ? 8'h20 : 8'h00));
      if (k > 1 && k < 6)
        chk_d("interleave", m[4 + (2 ^ (k - 2))], dq_out);
    end
    chk_f("pipe_desel", 1'b0, dq_oe);
    $display("test pipeline burst done");
    sleep_request = 1;
    repeat (4) cmd(8'h00);
    chk_f("sleep_on", 1'b1, sleep_active);
    // write while asleep must be ignored
    cmd(8'ha4, 4);
    cmd(8'h00);
    sleep_request = 0;
    repeat (5) cmd(8'h00);
    chk_f("sleep_off", 1'b0, sleep_active);
    cmd(8'h20);
    cmd(8'ha0, 4);
    cmd(8'h00);
    cmd(8'h00);
    chk_d("retained", m[4], dq_out);
    // async pulses wait a cycle: the latency check must first see its word
    cmd(8'h00);
    chk_d("no_step_hold", m[4], dq_out);
    chk_f("oe_on", 1'b1, dq_oe);
    output_enable_n = 1;
    #1 chk_f("oe_async", 1'b0, dq_oe);
    output_enable_n = 0;
    cmd(8'h00);
    sleep_request = 1;
    #1 chk_f("sleep_async", 1'b0, dq_oe);
    sleep_request = 0;
    $display("test sleep done");
    give_verdict();
  end
endmodule : sbsp_port_bench
